/* logic/hdm_i2c_wr.sv */
// i2c master that writes one three-byte frame: address, register, data
`timescale 1ns/1ps
`include "hdm_map.svh"

module hdm_i2c_wr #(
  parameter int QTR = `HDM_I2C_QTR
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [23:0] frame_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o
);

  logic [1:0]       meta_q, sync_q;
  hdm_pkg::hdm_ist_t st_q, st_d;
  logic [1:0]       ph_q, ph_d;
  logic [7:0]       div_q, div_d;
  logic [26:0]      sh_q, sh_d;
  logic [4:0]       cnt_q, cnt_d;
  logic             nack_q, nack_d, scl_q, scl_d, sda_q, sda_d;
  logic             tick, scl_hi, sda_hi;

  assign scl_hi = sync_q[1];
  assign sda_hi = sync_q[0];
  // clock stretching holds the high phase until the line really is high
  assign tick   = (div_q == 8'(QTR - 1)) && !(st_q == hdm_pkg::IST_BITS && ph_q == 2'h2 && !scl_hi);

  always_comb begin
    st_d   = st_q;
    ph_d   = ph_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    nack_d = nack_q;
    scl_d  = scl_q;
    sda_d  = sda_q;
    div_d  = (st_q == hdm_pkg::IST_IDLE || div_q == 8'(QTR - 1)) ? 8'h00 : div_q + 8'h01;
    done_o = 1'b0;
    case (st_q)
      hdm_pkg::IST_IDLE: begin
        if (start_i) begin
          sh_d   = {frame_i[23:16], 1'b1, frame_i[15:8], 1'b1, frame_i[7:0], 1'b1};
          cnt_d  = 5'h00;
          nack_d = 1'b0;
          ph_d   = 2'h0;
          st_d   = hdm_pkg::IST_START;
        end
      end
      hdm_pkg::IST_START: if (tick) begin
        if (ph_q == 2'h0) begin
          sda_d = 1'b1;
          ph_d  = 2'h1;
        end else begin
          scl_d = 1'b1;
          ph_d  = 2'h0;
          st_d  = hdm_pkg::IST_BITS;
        end
      end
      hdm_pkg::IST_BITS: if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sda_d = ~sh_q[26];
          2'h1: scl_d = 1'b0;
          2'h2: if ((cnt_q == 5'd8 || cnt_q == 5'd17 || cnt_q == 5'd26) && sda_hi) nack_d = 1'b1;
          default: begin
            scl_d = 1'b1;
            sh_d  = {sh_q[25:0], 1'b1};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'd26) begin
              st_d = hdm_pkg::IST_STOP;
            end
          end
        endcase
      end
      hdm_pkg::IST_STOP: if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sda_d = 1'b1;
          2'h1: scl_d = 1'b0;
          default: begin
            sda_d  = 1'b0;
            ph_d   = 2'h0;
            done_o = 1'b1;
            st_d   = hdm_pkg::IST_IDLE;
          end
        endcase
      end
      default: st_d = hdm_pkg::IST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      st_q   <= hdm_pkg::IST_IDLE;
      ph_q   <= 2'h0;
      div_q  <= 8'h00;
      sh_q   <= '1;
      cnt_q  <= 5'h00;
      nack_q <= 1'b0;
      scl_q  <= 1'b0;
      sda_q  <= 1'b0;
    end else if (ce_i) begin
      meta_q <= {scl_i, sda_i};
      sync_q <= meta_q;
      st_q   <= st_d;
      ph_q   <= ph_d;
      div_q  <= div_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      nack_q <= nack_d;
      scl_q  <= scl_d;
      sda_q  <= sda_d;
    end
  end

  assign busy_o   = (st_q != hdm_pkg::IST_IDLE);
  assign nack_o   = nack_q;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_q;
  assign sda_oe_o = sda_q;

endmodule : hdm_i2c_wr

/* logic/hdm_map.svh */
// offsets, field values and timing counts of the pattern and audio source
`ifndef HDM_MAP_SVH
`define HDM_MAP_SVH

`define HDM_CLK_HZ        40000000
`define HDM_MODES         5
// timing words: hact, hfp, hsync, hbp, vact, vfp, vsync, vbp
`define HDM_TIM0          96'h280_010_060_030_1e0_00a_002_021
`define HDM_TIM1          96'h2d0_010_03e_03c_1e0_009_006_01e
`define HDM_TIM2          96'h400_018_088_0a0_300_003_006_01d
`define HDM_TIM3          96'h500_030_070_0f8_400_001_003_026
`define HDM_TIM4          96'h780_058_02c_094_438_004_005_024

`define HDM_I2C_HZ        100000
`define HDM_I2C_QTR       (`HDM_CLK_HZ / (4 * `HDM_I2C_HZ))
`define HDM_TX_ADDR       8'h72
`define HDM_REG_AUD_VID   8'h15
`define HDM_REG_FMT       8'haf
`define HDM_CFG_LEN       8
`define HDM_CFG0          16'h4110
`define HDM_CFG1          16'h9803
`define HDM_CFG2          {`HDM_REG_AUD_VID, 8'h20}
`define HDM_CFG3          16'h1630
`define HDM_CFG4          {`HDM_REG_FMT, 8'h16}
`define HDM_CFG5          16'h0a01
`define HDM_CFG6          16'h0218
`define HDM_CFG7          16'h0c84

`define HDM_AUD_FS_HZ     48000
`define HDM_AUD_FS_MAX_HZ 192000
`define HDM_AUD_CH        2
`define HDM_AUD_BITS      16
`define HDM_BCLK_HZ       (`HDM_AUD_FS_HZ * `HDM_AUD_CH * `HDM_AUD_BITS)
`define HDM_NCO_STEP      (64'd2 * `HDM_BCLK_HZ * 64'h1_0000_0000 / `HDM_CLK_HZ)
`define HDM_SINE_LEN      16

`define HDM_DEB_MS        20
`define HDM_DEB_CYC       (`HDM_DEB_MS * (`HDM_CLK_HZ / 1000))

`endif

/* logic/hdm_pkg.sv */
// types shared by the pattern and audio source
package hdm_pkg;

  typedef struct packed {
    logic [11:0] hact;
    logic [11:0] hfp;
    logic [11:0] hsw;
    logic [11:0] hbp;
    logic [11:0] vact;
    logic [11:0] vfp;
    logic [11:0] vsw;
    logic [11:0] vbp;
  } hdm_tim_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } hdm_rgb_t;

  typedef struct packed {
    logic     de;
    logic     hs;
    logic     vs;
    hdm_rgb_t rgb;
  } hdm_vid_t;

  typedef enum logic [1:0] {MST_RUN = 2'h0, MST_REQ = 2'h1, MST_DROP = 2'h3, MST_LOCK = 2'h2} hdm_mst_t;
  typedef enum logic [1:0] {CST_IDLE = 2'h0, CST_SEND = 2'h1, CST_WAIT = 2'h3, CST_DONE = 2'h2} hdm_cst_t;
  typedef enum logic [1:0] {IST_IDLE = 2'h0, IST_START = 2'h1, IST_BITS = 2'h3, IST_STOP = 2'h2} hdm_ist_t;

endpackage : hdm_pkg

/* logic/hdm_src.sv */
// video pattern, mode stepping, i2s tone and transmitter setup
// Behaviour
// RQ1: each pixel is 24 bits, red in 23:16, green in 15:8, blue in 7:0, no subsampling.
// RQ2: the active timing is one of five built-in 60 Hz progressive modes, ids 0 to 4.
// RQ3: each press of the mode step button moves to the next mode, wrapping after the last. Presses while the pll retunes or within DEB_CYC are ignored.
// RQ4: a mode change asks the pixel clock pll to retune to the new mode's pixel clock.
// RQ5: the transmitter is set up over i2c before video and audio are expected from it. Only audio waits for cfg_done_o; video starts at pll lock.
// RQ6: a hot plug detect interrupt reruns the whole i2c setup sequence.
// RQ7: the setup writes the video format and audio rate register 0x15 and the format register 0xaf.
// RQ8: tone samples are sent only while the audio enable switch is on, silence otherwise.
// RQ9: audio leaves as standard i2s with 16 bits per channel.
// RQ10: each sample is shifted out most significant bit first.
// RQ11: the sample rate is 48 kHz and the bit clock is derived from it.
// RQ12: samples come from a table of precomputed sine values.
// RQ13: the stream keeps to two channels and a rate no higher than 192 kHz.
// RQ14: after a mode change video stays blanked until pll lock, then restarts at a new frame.
`timescale 1ns/1ps
`include "hdm_map.svh"

module hdm_src #(
  parameter int DEB_CYC = `HDM_DEB_CYC,
  parameter int I2C_QTR = `HDM_I2C_QTR
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         pix_clk_i,
  input  wire logic         pll_locked_i,
  input  wire logic         mode_step_button_n_i,
  input  wire logic         audio_enable_switch_i,
  input  wire logic         hpd_int_n_i,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output hdm_pkg::hdm_vid_t vid_o,
  output logic              pll_reconfig_o,
  output logic [2:0]        pll_mode_o,
  output logic              cfg_done_o,
  output logic              i2s_bclk_o,
  output logic              i2s_lrclk_o,
  output logic              i2s_sd_o,
  output logic              scl_o,
  output logic              scl_oe_o,
  output logic              sda_o,
  output logic              sda_oe_o
);

  localparam logic [15:0] CFG [`HDM_CFG_LEN] = '{`HDM_CFG0, `HDM_CFG1, `HDM_CFG2, `HDM_CFG3,
                                                `HDM_CFG4, `HDM_CFG5, `HDM_CFG6, `HDM_CFG7};
  localparam logic [15:0] SINE [`HDM_SINE_LEN] = '{16'h0000, 16'h187e, 16'h2d41, 16'h3b21,
                                                  16'h4000, 16'h3b21, 16'h2d41, 16'h187e,
                                                  16'h0000, 16'he782, 16'hd2bf, 16'hc4df,
                                                  16'hc000, 16'hc4df, 16'hd2bf, 16'he782};
  localparam logic [32:0] NCO_STEP = 33'(`HDM_NCO_STEP);

  // input synchronisers: {hpd_n, switch, button_n, locked, pix_clk}
  logic [4:0] meta_q, sync_q, prev_q;
  logic       pix_rise, btn_press, hpd_event, locked, aud_sw;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 5'h14;
      sync_q <= 5'h14;
      prev_q <= 5'h14;
    end else if (ce_i) begin
      meta_q <= {hpd_int_n_i, audio_enable_switch_i, mode_step_button_n_i, pll_locked_i, pix_clk_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pix_rise  = sync_q[0] & ~prev_q[0];
  assign locked    = sync_q[1];
  assign btn_press = ~sync_q[2] & prev_q[2];
  assign aud_sw    = sync_q[3];
  assign hpd_event = ~sync_q[4] & prev_q[4];

  // mode control and pll retune handshake
  hdm_pkg::hdm_mst_t mst_q, mst_d;
  logic [2:0]        mode_q, mode_d;
  logic [19:0]       deb_q, deb_d;

  always_comb begin
    mst_d  = mst_q;
    mode_d = mode_q;
    deb_d  = (deb_q != 20'h00000) ? deb_q - 20'h00001 : deb_q;
    case (mst_q)
      hdm_pkg::MST_RUN: begin
        if (btn_press && deb_q == 20'h00000) begin
          deb_d  = 20'(DEB_CYC);
          mode_d = (mode_q == 3'(`HDM_MODES - 1)) ? 3'h0 : mode_q + 3'h1; // RQ3
          mst_d  = hdm_pkg::MST_REQ;
        end
      end
      hdm_pkg::MST_REQ:  mst_d = hdm_pkg::MST_DROP; // RQ4
      hdm_pkg::MST_DROP: if (!locked) mst_d = hdm_pkg::MST_LOCK;
      hdm_pkg::MST_LOCK: if (locked) mst_d = hdm_pkg::MST_RUN; // RQ14
      default:           mst_d = hdm_pkg::MST_LOCK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst_q  <= hdm_pkg::MST_LOCK;
      mode_q <= 3'h0;
      deb_q  <= 20'h00000;
    end else if (ce_i) begin
      mst_q  <= mst_d;
      mode_q <= mode_d;
      deb_q  <= deb_d;
    end
  end

  assign pll_reconfig_o = (mst_q == hdm_pkg::MST_REQ); // RQ4
  assign pll_mode_o     = mode_q;

  // timing generator and colour bar pattern
  function automatic hdm_pkg::hdm_tim_t tim_sel(input logic [2:0] m);
    case (m) // RQ2
      3'h0:    tim_sel = hdm_pkg::hdm_tim_t'(`HDM_TIM0);
      3'h1:    tim_sel = hdm_pkg::hdm_tim_t'(`HDM_TIM1);
      3'h2:    tim_sel = hdm_pkg::hdm_tim_t'(`HDM_TIM2);
      3'h3:    tim_sel = hdm_pkg::hdm_tim_t'(`HDM_TIM3);
      default: tim_sel = hdm_pkg::hdm_tim_t'(`HDM_TIM4);
    endcase
  endfunction : tim_sel

  hdm_pkg::hdm_tim_t tim;
  hdm_pkg::hdm_vid_t vid_q, vid_d;
  logic [11:0]       h_q, h_d, v_q, v_d, htot, vtot, hs0, vs0;
  logic [2:0]        bar;

  assign tim  = tim_sel(mode_q);
  assign htot = tim.hact + tim.hfp + tim.hsw + tim.hbp;
  assign vtot = tim.vact + tim.vfp + tim.vsw + tim.vbp;
  assign hs0  = tim.hact + tim.hfp;
  assign vs0  = tim.vact + tim.vfp;
  assign bar  = h_q[9:7];

  always_comb begin
    h_d   = h_q;
    v_d   = v_q;
    vid_d = vid_q;
    if (mst_q != hdm_pkg::MST_RUN) begin
      h_d   = 12'h000; // RQ14
      v_d   = 12'h000;
      vid_d = '0;
    end else if (pix_rise) begin
      vid_d.de    = (h_q < tim.hact) && (v_q < tim.vact);
      vid_d.hs    = (h_q >= hs0) && (h_q < hs0 + tim.hsw);
      vid_d.vs    = (v_q >= vs0) && (v_q < vs0 + tim.vsw);
      vid_d.rgb.r = vid_d.de ? {8{bar[2]}} : 8'h00; // RQ1
      vid_d.rgb.g = vid_d.de ? {8{bar[1]}} : 8'h00;
      vid_d.rgb.b = vid_d.de ? {8{bar[0]}} : 8'h00;
      if (h_q == htot - 12'h001) begin
        h_d = 12'h000;
        v_d = (v_q == vtot - 12'h001) ? 12'h000 : v_q + 12'h001;
      end else begin
        h_d = h_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_q   <= 12'h000;
      v_q   <= 12'h000;
      vid_q <= '0;
    end else if (ce_i) begin
      h_q   <= h_d;
      v_q   <= v_d;
      vid_q <= vid_d;
    end
  end

  assign vid_o = vid_q;

  // transmitter setup sequencer
  hdm_pkg::hdm_cst_t cst_q, cst_d;
  logic [2:0]        cidx_q, cidx_d;
  logic              pend_q, pend_d, i2c_start, i2c_done, i2c_nack;

  always_comb begin
    cst_d     = cst_q;
    cidx_d    = cidx_q;
    pend_d    = pend_q | hpd_event; // RQ6
    i2c_start = 1'b0;
    case (cst_q)
      hdm_pkg::CST_IDLE: cst_d = hdm_pkg::CST_SEND;
      hdm_pkg::CST_SEND: begin
        i2c_start = 1'b1; // RQ5
        cst_d     = hdm_pkg::CST_WAIT;
      end
      hdm_pkg::CST_WAIT: begin
        if (i2c_done) begin
          cst_d = hdm_pkg::CST_SEND;
          if (!i2c_nack) begin
            if (cidx_q == 3'(`HDM_CFG_LEN - 1)) begin
              cst_d = hdm_pkg::CST_DONE;
            end else begin
              cidx_d = cidx_q + 3'h1; // RQ7
            end
          end
        end
      end
      hdm_pkg::CST_DONE: begin
        if (pend_q) begin
          pend_d = hpd_event; // RQ6
          cidx_d = 3'h0;
          cst_d  = hdm_pkg::CST_SEND;
        end
      end
      default: cst_d = hdm_pkg::CST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cst_q  <= hdm_pkg::CST_IDLE;
      cidx_q <= 3'h0;
      pend_q <= 1'b0;
    end else if (ce_i) begin
      cst_q  <= cst_d;
      cidx_q <= cidx_d;
      pend_q <= pend_d;
    end
  end

  assign cfg_done_o = (cst_q == hdm_pkg::CST_DONE);

  hdm_i2c_wr #(
    .QTR      (I2C_QTR)
  ) u_i2c (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .start_i  (i2c_start),
    .frame_i  ({`HDM_TX_ADDR, CFG[cidx_q]}),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .busy_o   (),
    .done_o   (i2c_done),
    .nack_o   (i2c_nack),
    .scl_o    (scl_o),
    .scl_oe_o (scl_oe_o),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe_o)
  );

  // i2s tone generator, bit clock from a phase accumulator
  logic [31:0] acc_q, acc_d;
  logic        carry, aud_on;
  logic        bclk_q, bclk_d, lr_q, lr_d, sd_q, sd_d;
  logic [4:0]  bcnt_q, bcnt_d, pos;
  logic [3:0]  sidx_q, sidx_d;
  logic [15:0] samp_q, samp_d;

  assign aud_on = aud_sw && cfg_done_o; // RQ8

  always_comb begin
    {carry, acc_d} = {1'b0, acc_q} + NCO_STEP; // RQ11
    bclk_d = bclk_q;
    bcnt_d = bcnt_q;
    lr_d   = lr_q;
    sd_d   = sd_q;
    sidx_d = sidx_q;
    samp_d = samp_q;
    pos    = bcnt_q;
    if (carry) begin
      bclk_d = ~bclk_q;
      if (bclk_q) begin
        // falling edge: two 16-bit slots per frame, data one bit behind word select
        bcnt_d = bcnt_q + 5'h01; // RQ13
        pos    = bcnt_d - 5'h01;
        lr_d   = bcnt_d[4]; // RQ9
        sd_d   = aud_on ? samp_q[4'(4'hf - pos[3:0])] : 1'b0; // RQ10
        if (bcnt_d == 5'h00) begin
          samp_d = aud_on ? SINE[sidx_q] : 16'h0000; // RQ12
          sidx_d = aud_on ? sidx_q + 4'h1 : sidx_q;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q  <= 32'h00000000;
      bclk_q <= 1'b0;
      bcnt_q <= 5'h00;
      lr_q   <= 1'b0;
      sd_q   <= 1'b0;
      sidx_q <= 4'h0;
      samp_q <= 16'h0000;
    end else if (ce_i) begin
      acc_q  <= acc_d;
      bclk_q <= bclk_d;
      bcnt_q <= bcnt_d;
      lr_q   <= lr_d;
      sd_q   <= sd_d;
      sidx_q <= sidx_d;
      samp_q <= samp_d;
    end
  end

  assign i2s_bclk_o  = bclk_q;
  assign i2s_lrclk_o = lr_q;
  assign i2s_sd_o    = sd_q;

endmodule : hdm_src

/* verification/hdm_src_checker.sv */
// concurrent checks on the pattern and audio source ports
`timescale 1ns/1ps

module hdm_src_checker #(
  parameter int DEB_CYC = 4,
  parameter int I2C_QTR = 4
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              pix_clk_i,
  input wire logic              pll_locked_i,
  input wire logic              mode_step_button_n_i,
  input wire logic              audio_enable_switch_i,
  input wire logic              hpd_int_n_i,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire hdm_pkg::hdm_vid_t vid_o,
  input wire logic              pll_reconfig_o,
  input wire logic [2:0]        pll_mode_o,
  input wire logic              cfg_done_o,
  input wire logic              i2s_bclk_o,
  input wire logic              i2s_lrclk_o,
  input wire logic              i2s_sd_o,
  input wire logic              scl_o,
  input wire logic              scl_oe_o,
  input wire logic              sda_o,
  input wire logic              sda_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // cycles the switch has been off, saturating
  logic [9:0] off_q;
  logic [9:0] off_d;

  always_comb begin
    off_d = audio_enable_switch_i ? 10'h000 : off_q + {9'h000, off_q != 10'h3ff};
  end

  always_ff @(posedge clk_i) begin
    off_q <= rst_i ? 10'h000 : off_d;
  end

  sequence s_bclk_hi;
    i2s_bclk_o [*8] ##1 i2s_bclk_o [*5];
  endsequence

  property p_rst;
    $fell(rst_i) |-> vid_o == '0 && !pll_reconfig_o && !cfg_done_o && !scl_oe_o && !sda_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");

  property p_pulse;
    pll_reconfig_o |=> !pll_reconfig_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reconfig pulse too long");

  property p_step;
    pll_reconfig_o |-> pll_mode_o == (($past(pll_mode_o) == 3'h4) ? 3'h0 : $past(pll_mode_o) + 3'h1);
  endproperty
  a_step: assert property (p_step) else $error("mode did not advance by one");

  property p_hold;
    $changed(pll_mode_o) |-> pll_reconfig_o;
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without retune");

  property p_range;
    pll_mode_o <= 3'h4;
  endproperty
  a_range: assert property (p_range) else $error("mode id out of range");

  property p_blank;
    pll_reconfig_o |=> !vid_o.de [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("video active during retune");

  property p_mute;
    off_q >= 10'h384 |-> !i2s_sd_o;
  endproperty
  a_mute: assert property (p_mute) else $error("tone while switch off");

  property p_lr;
    $changed(i2s_lrclk_o) |-> $fell(i2s_bclk_o);
  endproperty
  a_lr: assert property (p_lr) else $error("word clock moved off bit clock fall");

  property p_sd;
    $changed(i2s_sd_o) |-> $fell(i2s_bclk_o);
  endproperty
  a_sd: assert property (p_sd) else $error("serial data moved off bit clock fall");

  property p_bclk;
    $rose(i2s_bclk_o) |-> s_bclk_hi ##[1:2] !i2s_bclk_o;
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock half period wrong");

  property p_hpd;
    $fell(hpd_int_n_i) && cfg_done_o |-> ##[1:8] !cfg_done_o;
  endproperty
  a_hpd: assert property (p_hpd) else $error("hot plug did not restart setup");
endmodule : hdm_src_checker

bind hdm_src hdm_src_checker #(.DEB_CYC(DEB_CYC), .I2C_QTR(I2C_QTR)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pix_clk_i(pix_clk_i), .pll_locked_i(pll_locked_i),
  .mode_step_button_n_i(mode_step_button_n_i), .audio_enable_switch_i(audio_enable_switch_i),
  .hpd_int_n_i(hpd_int_n_i), .scl_i(scl_i), .sda_i(sda_i), .vid_o(vid_o), .pll_reconfig_o(pll_reconfig_o),
  .pll_mode_o(pll_mode_o), .cfg_done_o(cfg_done_o), .i2s_bclk_o(i2s_bclk_o), .i2s_lrclk_o(i2s_lrclk_o),
  .i2s_sd_o(i2s_sd_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

/* verification/hdm_tx_model.sv */
// transmitter stand-in: i2c write target and pixel pll lock
`timescale 1ns/1ps

module hdm_tx_model (
  input  wire logic  clk_i,
  input  wire logic  pll_reconfig_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       pll_locked_o,
  output logic       ack_o,
  output logic [7:0] addr_o,
  output logic [7:0] reg15_o,
  output logic [7:0] regaf_o,
  output int         nfr_o
);
  logic [7:0] sr;
  logic [7:0] ra;
  int         cnt;
  int         nb;
  int         lk;

  initial begin
    pll_locked_o = 1'b1;
    ack_o = 1'b0;
    nfr_o = 0;
    cnt = 0;
    nb = 0;
    lk = 0;
  end

  // lock drops after a retune, then comes back
  always @(posedge clk_i) begin
    if (pll_reconfig_i) lk <= 1;
    else if (lk > 0) lk <= lk + 1;
    if (lk == 10) pll_locked_o <= 1'b0;
    if (lk == 40) begin
      pll_locked_o <= 1'b1;
      lk <= 0;
    end
  end

  always @(negedge sda_i) if (scl_i) begin
    cnt = 0;
    nb = 0;
    ack_o = 1'b0;
  end

  always @(posedge sda_i) if (scl_i && nb == 3) nfr_o++;

  always @(posedge scl_i) begin
    if (cnt < 8) sr = {sr[6:0], sda_i};
    cnt++;
  end

  always @(negedge scl_i) begin
    if (cnt == 8) begin
      ack_o = 1'b1;
      if (nb == 0) addr_o = sr;
      if (nb == 1) ra = sr;
      if (nb == 2 && ra == 8'h15) reg15_o = sr;
      if (nb == 2 && ra == 8'haf) regaf_o = sr;
      nb++;
    end else if (cnt == 9) begin
      ack_o = 1'b0;
      cnt = 0;
    end
  end
endmodule : hdm_tx_model

/* verification/tb_top.sv */
// self-checking bench for the pattern and audio source
`timescale 1ns/1ps

module tb_top;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              pix_clk = 1'b0;
  logic              btn_n = 1'b1;
  logic              sw = 1'b0;
  logic              hpd_n = 1'b1;
  logic              rcfg, done, bclk, lrclk, sd, scl_oe, sda_oe, ack, locked;
  logic [2:0]        mode;
  logic [7:0]        addr, r15, raf;
  hdm_pkg::hdm_vid_t vid;
  int                nfr;
  int                mismatches = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                hact [5] = '{640, 720, 1024, 1280, 1920};
  int                hfp [5] = '{16, 16, 24, 48, 88};
  int                hsw [5] = '{96, 62, 136, 112, 44};
  wire               scl = ~scl_oe;
  wire               sda = ~(sda_oe | ack);

  always #12.5 clk_i = ~clk_i;
  always #100 pix_clk = ~pix_clk;

  hdm_src #(.DEB_CYC(4), .I2C_QTR(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pix_clk_i(pix_clk), .pll_locked_i(locked),
    .mode_step_button_n_i(btn_n), .audio_enable_switch_i(sw), .hpd_int_n_i(hpd_n),
    .scl_i(scl), .sda_i(sda), .vid_o(vid), .pll_reconfig_o(rcfg), .pll_mode_o(mode),
    .cfg_done_o(done), .i2s_bclk_o(bclk), .i2s_lrclk_o(lrclk), .i2s_sd_o(sd),
    .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe));

  hdm_tx_model u_tx (
    .clk_i(clk_i), .pll_reconfig_i(rcfg), .scl_i(scl), .sda_i(sda), .pll_locked_o(locked),
    .ack_o(ack), .addr_o(addr), .reg15_o(r15), .regaf_o(raf), .nfr_o(nfr));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      mismatches++;
      test_done;
    end
  end

  task t_setup;
    int i;
    for (i = 0; i < 8000 && done !== 1'b1; i++) @(negedge clk_i);
    chk("cfg_done", done, 1);
    chk("frames", nfr, 8);
    chk("addr", addr, 8'h72);
    chk("reg15", r15, 8'h20);
    chk("regaf", raf, 8'h16);
  endtask : t_setup

  // one active line: width, two colour bars and the line sync after it
  task automatic t_line(input int m);
    int i;
    int n;
    int k;
    for (i = 0; i < 8000 && vid.de !== 1'b0; i++) @(negedge clk_i);
    for (i = 0; i < 8000 && vid.de !== 1'b1; i++) @(negedge clk_i);
    for (n = 0; n < 20000 && vid.de === 1'b1; n++) begin
      if (n == 1028) chk("bar1", vid.rgb, 24'h0000ff);
      if (n == 1028) chk("vsync", vid.vs, 1'b0);
      if (n == 3076) chk("bar3", vid.rgb, 24'h00ffff);
      @(negedge clk_i);
    end
    chk("active", (n + 4) / 8, hact[m]);
    for (n = 0; n < 8000 && vid.hs !== 1'b1; n++) @(negedge clk_i);
    for (k = 0; k < 8000 && vid.hs === 1'b1; k++) @(negedge clk_i);
    chk("front porch", (n + 4) / 8, hfp[m]);
    chk("hsync", (k + 4) / 8, hsw[m]);
  endtask : t_line

  task t_modes;
    int m;
    int i;
    for (m = 1; m <= 5; m++) begin
      @(negedge clk_i) btn_n = 1'b0;
      for (i = 0; i < 20 && rcfg !== 1'b1; i++) @(negedge clk_i);
      chk("reconfig", rcfg, 1);
      chk("mode", mode, m % 5);
      @(negedge clk_i) btn_n = 1'b1;
      if (m == 1) begin
        repeat (10) @(negedge clk_i);
        btn_n = 1'b0;
        repeat (8) @(negedge clk_i);
        btn_n = 1'b1;
      end
      t_line(m % 5);
      chk("mode held", mode, m % 5);
    end
  endtask : t_modes

  // two whole frames back to back: the right lsb lands in the next frame's first slot
  task t_audio;
    logic [63:0] w;
    int          t;
    int          n;
    @(negedge clk_i) sw = 1'b1;
    repeat (1000) @(negedge clk_i);
    @(negedge lrclk);
    repeat (2) begin
      t = cyc;
      @(negedge lrclk);
      chk("frame len", (cyc - t) >= 833 && (cyc - t) <= 834, 1);
    end
    @(posedge bclk);
    repeat (64) begin
      @(posedge bclk);
      w = {w[62:0], sd};
    end
    chk("pair", w[63:48], w[47:32]);
    chk("pair next", w[31:16], w[15:0]);
    chk("tone steps", w[63:48] !== w[31:16], 1);
    @(negedge clk_i) sw = 1'b0;
    repeat (1000) @(negedge clk_i);
    n = 0;
    repeat (900) begin
      @(negedge clk_i);
      n += sd;
    end
    chk("mute", n, 0);
  endtask : t_audio

  task t_hpd;
    int i;
    @(negedge clk_i) hpd_n = 1'b0;
    for (i = 0; i < 20 && done !== 1'b0; i++) @(negedge clk_i);
    chk("rerun", done, 0);
    hpd_n = 1'b1;
    for (i = 0; i < 8000 && done !== 1'b1; i++) @(negedge clk_i);
    chk("frames again", nfr, 16);
  endtask : t_hpd

  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    t_setup;
    t_line(0);
    t_modes;
    t_audio;
    t_hpd;
    test_done;
  end
endmodule : tb_top
